/* File: cpu_state_pkg.sv */
package cpu_state_pkg;

  // ****************************************************************
  // Register map, byte offsets on the 12-bit bus address
  // ****************************************************************
  localparam logic [11:0] OFS_CORE   = 12'h000;  // Sixteen words, index 0 to 15.
  localparam logic [11:0] OFS_COMBINED_STATUS_WORD   = 12'h040;
  localparam logic [11:0] OFS_APPLICATION_STATUS   = 12'h044;
  localparam logic [11:0] OFS_INTERRUPT_STATUS_NUMBER   = 12'h048;
  localparam logic [11:0] OFS_EXECUTION_STATUS   = 12'h04C;
  localparam logic [11:0] OFS_PRIM   = 12'h050;
  localparam logic [11:0] OFS_FMASK  = 12'h054;
  localparam logic [11:0] OFS_BPRI   = 12'h058;
  localparam logic [11:0] OFS_CTRL   = 12'h05C;
  localparam logic [11:0] OFS_MSP    = 12'h060;
  localparam logic [11:0] OFS_PSP    = 12'h064;
  localparam logic [11:0] OFS_STATE  = 12'h068;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  localparam logic [31:0] APPLICATION_STATUS_MASK  = 32'hF800_0000;
  localparam logic [31:0] INTERRUPT_STATUS_NUMBER_MASK  = 32'h0000_01FF;
  localparam logic [31:0] EXECUTION_STATUS_MASK  = 32'h0600_FC00;
  localparam int          EXECUTION_STATUS_T_BIT = 24;
  localparam logic [31:0] SP_MASK    = 32'hFFFF_FFFC;
  localparam logic [31:0] PC_MASK    = 32'hFFFF_FFFE;
  localparam int          CTRL_USER  = 0;
  localparam int          CTRL_SPSEL = 1;
  localparam int          IDX_SP     = 13;
  localparam int          IDX_LR     = 14;
  localparam int          IDX_PC     = 15;
  localparam int          IDX_HI_LO  = 8;
  localparam int          IDX_HI_HI  = 12;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] EXECUTION_STATUS_RST   = 32'h0100_0000;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;

  // Operating states; handler at user level has no code.
  typedef enum logic [2:0] {
    ST_PRIV_HANDLER = 3'b001,
    ST_PRIV_THREAD  = 3'b010,
    ST_USER_THREAD  = 3'b100
  } op_state_t;

endpackage

/* File: cpu_mode_and_core_registers.sv */
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - Only privileged handler, privileged/user thread states
// - User-level special accesses blocked, raise fault
// - Exception service runs privileged handler, else thread
// - Sixteen core registers each hold 32 bits
// - Registers 8-12 unreachable by narrow instructions
// - Process stack only in user thread mode
// - Stack pointer low two bits forced zero
// - Subroutine call loads return address register
// - Program counter bit zero forced zero
// - Application status flags live in bits 27-31
// - Interrupt status holds active exception number
// - Execution status keeps bits 10-15, 25-26
// - Bit 24 reads one; clearing it faults
// - Status parts accessible combined and individually
// - Primary mask passes only nonmaskable and hard fault
// - Fault mask passes only nonmaskable interrupt
// - Nonzero threshold blocks equal or larger priorities
// - Control bit 0 selects thread privilege
// - Control bit 1 is stored, zero in handler; stack follows user thread state
// - Bit-band alias maps single bits of memory
// - Unaligned data accesses are allowed and split
module cpu_mode_and_core_registers #(
  parameter logic [31:0] SRAM_BASE = 32'h1000_0000,
  parameter logic [31:0] BB_BASE   = 32'h1200_0000,
  parameter int          BB_BYTES  = 32'h0010_0000,
  parameter int          PRIO_W    = 9
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              narrow_insn,
  input  wire logic              exc_enter,
  input  wire logic [8:0]        exc_num,
  input  wire logic              exc_exit,
  input  wire logic [8:0]        exc_ret_num,
  input  wire logic              call_valid,
  input  wire logic [31:0]       call_ret_addr,
  input  wire logic [31:0]       call_target,
  input  wire logic              flags_valid,
  input  wire logic [4:0]        flags_in,
  input  wire logic              irq_valid,
  input  wire logic              irq_is_nmi,
  input  wire logic              irq_is_hardfault,
  input  wire logic [PRIO_W-1:0] irq_prio,
  input  wire logic [31:0]       bb_addr,
  input  wire logic [31:0]       ua_addr,
  input  wire logic [2:0]        ua_bytes,
  output logic                   fault,
  output logic                   irq_take,
  output logic [2:0]             op_state,
  output logic                   psp_active,
  output logic [31:0]            instruction_pointer,
  output logic                   bb_hit,
  output logic [31:0]            bb_word_addr,
  output logic [4:0]             bb_bit,
  output logic                   ua_split
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Special registers are privileged; combined and application status,
  // the state word and core registers stay open to user code.
  function automatic logic is_special(input logic [11:0] a);
    is_special = (a >= cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER) && (a != cpu_state_pkg::OFS_STATE);
  endfunction

  // Only whole words inside the map answer; anything else is refused.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= cpu_state_pkg::OFS_STATE);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  // Slot 13 of the array is never used: the stack pointer lives in the
  // two banked words below, so a write to index 13 lands in one of them.
  logic [31:0] gpr_q [16];
  logic [31:0] gpr_d [16];
  logic [31:0] msp_q, msp_d, psp_q, psp_d;
  logic [31:0] application_status_q, application_status_d, interrupt_status_number_q, interrupt_status_number_d, execution_status_q, execution_status_d;
  logic        prim_q, prim_d, fmask_q, fmask_d;
  logic [PRIO_W-1:0] bpri_q, bpri_d;
  logic [1:0]  ctrl_q, ctrl_d, saved_ctrl_q, saved_ctrl_d;
  logic [7:0]  depth_q, depth_d;
  cpu_state_pkg::op_state_t state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, fault_q, fault_d;
  logic        take_q, take_d, bb_hit_q, bb_hit_d, split_q, split_d;
  logic        psp_active_q, psp_active_d;
  logic [31:0] bb_word_q, bb_word_d;
  logic [4:0]  bb_bit_q, bb_bit_d;

  // Decode terms shared by the bus and the event logic.
  logic        setup, access, user_lvl, err, psp_sel;
  logic [31:0] combined_status_word, wv, bb_off;
  logic [3:0]  idx;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // The bus answers with no wait state: the setup cycle evaluates the
  // access and the access phase sees ready, data and error at once.
  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable && pready_q;
    user_lvl = (state_q == cpu_state_pkg::ST_USER_THREAD);
    psp_sel  = user_lvl;
    combined_status_word     = application_status_q | interrupt_status_number_q | execution_status_q;
    idx      = paddr[5:2];
    wv       = pwdata;
    // Every register here except fault holds its value unless a bus write or an event moves it; fault clears each cycle.
    gpr_d    = gpr_q;
    msp_d    = msp_q;
    psp_d    = psp_q;
    application_status_d   = application_status_q;
    interrupt_status_number_d   = interrupt_status_number_q;
    execution_status_d   = execution_status_q;
    prim_d   = prim_q;
    fmask_d  = fmask_q;
    bpri_d   = bpri_q;
    ctrl_d   = ctrl_q;
    saved_ctrl_d = saved_ctrl_q;
    depth_d  = depth_q;
    fault_d  = 1'b0;
    // Error cases: unmapped word, narrow access to high registers,
    // blocked privileged register, or an attempt to clear bit 24.
    err = !is_mapped(paddr);
    if (paddr < cpu_state_pkg::OFS_COMBINED_STATUS_WORD && narrow_insn &&
        idx >= 4'(cpu_state_pkg::IDX_HI_LO) && idx <= 4'(cpu_state_pkg::IDX_HI_HI)) begin
      err = 1'b1;
    end
    if (user_lvl && is_special(paddr)) begin
      err = 1'b1;
    end
    if (pwrite && !pwdata[cpu_state_pkg::EXECUTION_STATUS_T_BIT] &&
        (paddr == cpu_state_pkg::OFS_COMBINED_STATUS_WORD || paddr == cpu_state_pkg::OFS_EXECUTION_STATUS)) begin
      err = 1'b1;
    end
    // Ready follows every setup by exactly one cycle, refused or not, so
    // the master never waits on an error.
    pready_d  = setup;
    pslverr_d = setup && err;
    prdata_d  = cpu_state_pkg::WORD_RST;
    // Read data is captured at the setup edge and stands only in the
    // access phase; outside it the bus shows zero.
    if (setup && !err && !pwrite) begin
      unique case (paddr)
        cpu_state_pkg::OFS_COMBINED_STATUS_WORD:  prdata_d = combined_status_word;
        cpu_state_pkg::OFS_APPLICATION_STATUS:  prdata_d = application_status_q;
        cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER:  prdata_d = interrupt_status_number_q;
        cpu_state_pkg::OFS_EXECUTION_STATUS:  prdata_d = execution_status_q;
        cpu_state_pkg::OFS_PRIM:  prdata_d = {31'h0000_0000, prim_q};
        cpu_state_pkg::OFS_FMASK: prdata_d = {31'h0000_0000, fmask_q};
        cpu_state_pkg::OFS_BPRI:  prdata_d = 32'(bpri_q);
        cpu_state_pkg::OFS_CTRL:  prdata_d = {30'h0000_0000, ctrl_q};
        cpu_state_pkg::OFS_MSP:   prdata_d = msp_q;
        cpu_state_pkg::OFS_PSP:   prdata_d = psp_q;
        cpu_state_pkg::OFS_STATE: prdata_d = {28'h000_0000, psp_sel, state_q};
        default: begin
          if (idx == 4'(cpu_state_pkg::IDX_SP)) begin
            prdata_d = psp_sel ? psp_q : msp_q;
          end else begin
            prdata_d = gpr_q[idx];
          end
        end
      endcase
    end
    // Faults are set at the edge that closes the access phase, one for each
    // refused write, or refused user-level read, of a mapped word.
    if (access && pslverr_q && (user_lvl || pwrite)) begin
      fault_d = is_mapped(paddr);
    end
    // A write lands only at the edge that closes the access phase, and
    // only if the setup cycle raised no error, so a refused write is lost.
    if (access && !pslverr_q && pwrite) begin
      unique case (paddr)
        cpu_state_pkg::OFS_COMBINED_STATUS_WORD: begin
          application_status_d = wv & cpu_state_pkg::APPLICATION_STATUS_MASK;
          execution_status_d = (wv & cpu_state_pkg::EXECUTION_STATUS_MASK) | cpu_state_pkg::EXECUTION_STATUS_RST;
        end
        cpu_state_pkg::OFS_APPLICATION_STATUS:  application_status_d = wv & cpu_state_pkg::APPLICATION_STATUS_MASK;
        cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER:  interrupt_status_number_d = interrupt_status_number_q;
        cpu_state_pkg::OFS_EXECUTION_STATUS:
          execution_status_d = (wv & cpu_state_pkg::EXECUTION_STATUS_MASK) | cpu_state_pkg::EXECUTION_STATUS_RST;
        cpu_state_pkg::OFS_PRIM:  prim_d = wv[0];
        cpu_state_pkg::OFS_FMASK: fmask_d = wv[0];
        cpu_state_pkg::OFS_BPRI:  bpri_d = wv[PRIO_W-1:0];
        cpu_state_pkg::OFS_CTRL: begin
          ctrl_d[cpu_state_pkg::CTRL_USER] = wv[0];
          // The stack select stays zero while an exception runs.
          ctrl_d[cpu_state_pkg::CTRL_SPSEL] = wv[1] && (depth_q == 8'h00);
        end
        cpu_state_pkg::OFS_MSP:   msp_d = wv & cpu_state_pkg::SP_MASK;
        cpu_state_pkg::OFS_PSP:   psp_d = wv & cpu_state_pkg::SP_MASK;
        cpu_state_pkg::OFS_STATE: ctrl_d = ctrl_q;
        default: begin
          if (idx == 4'(cpu_state_pkg::IDX_SP)) begin
            if (psp_sel) begin
              psp_d = wv & cpu_state_pkg::SP_MASK;
            end else begin
              msp_d = wv & cpu_state_pkg::SP_MASK;
            end
          end else if (idx == 4'(cpu_state_pkg::IDX_PC)) begin
            gpr_d[idx] = wv & cpu_state_pkg::PC_MASK;
          end else begin
            gpr_d[idx] = wv;
          end
        end
      endcase
    end
    // Pipeline events take priority over a bus write in the same cycle.
    if (flags_valid) begin
      application_status_d = {flags_in, 27'h000_0000};
    end
    if (call_valid) begin
      gpr_d[cpu_state_pkg::IDX_LR] = call_ret_addr;
      gpr_d[cpu_state_pkg::IDX_PC] = call_target & cpu_state_pkg::PC_MASK;
    end
    // Depth counts active exceptions; control is saved on the first entry
    // only, so a nested return cannot restore it early. The counter is
    // eight bits wide; deeper nesting than that is not supported.
    if (exc_enter) begin
      if (depth_q == 8'h00) begin
        saved_ctrl_d = ctrl_d;
      end
      ctrl_d[cpu_state_pkg::CTRL_SPSEL] = 1'b0;
      interrupt_status_number_d  = 32'(exc_num);
      depth_d = depth_q + 8'h01;
    end else if (exc_exit && depth_q != 8'h00) begin
      depth_d = depth_q - 8'h01;
      if (depth_q == 8'h01) begin
        ctrl_d = saved_ctrl_q;
        interrupt_status_number_d = cpu_state_pkg::WORD_RST;
      end else begin
        interrupt_status_number_d = 32'(exc_ret_num);
      end
    end
    // Handler mode is always privileged, so a user handler never forms.
    if (depth_d != 8'h00) begin
      state_d = cpu_state_pkg::ST_PRIV_HANDLER;
    end else if (ctrl_d[cpu_state_pkg::CTRL_USER]) begin
      state_d = cpu_state_pkg::ST_USER_THREAD;
    end else begin
      state_d = cpu_state_pkg::ST_PRIV_THREAD;
    end
    // The stack flag is its own flop so the output has no decode behind it.
    psp_active_d = (state_d == cpu_state_pkg::ST_USER_THREAD);
  end

  // ****************************************************************
  // Interrupt masking, bit-band and unaligned helpers
  // ****************************************************************

  // Fault mask outranks primary mask; only the nonmaskable request
  // passes through both.
  always_comb begin
    take_d = 1'b0;
    if (irq_valid) begin
      if (irq_is_nmi) begin
        take_d = 1'b1;
      end else if (fmask_q) begin
        take_d = 1'b0;
      end else if (irq_is_hardfault) begin
        take_d = 1'b1;
      end else if (prim_q) begin
        take_d = 1'b0;
      end else begin
        take_d = (bpri_q == '0) || (irq_prio < bpri_q);
      end
    end
    // The hit test relies on the alias window not wrapping past the top
    // of the 32-bit address space; keep BB_BASE low enough for that.
    // Each alias word stands for one bit of the memory region.
    bb_off    = bb_addr - BB_BASE;
    bb_hit_d  = (bb_addr >= BB_BASE) && (bb_off < 32'(BB_BYTES) * 32'h0000_0020);
    bb_word_d = SRAM_BASE + {5'h00, bb_off[31:7], 2'h0};
    bb_bit_d  = {bb_off[6:2]} ;
    // An access crossing a word boundary is served as two words.
    // A four-bit sum keeps offset plus length from wrapping for long
    // accesses, which would otherwise look aligned.
    split_d = (4'(ua_addr[1:0]) + 4'(ua_bytes)) > 4'h4;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Control state resets to privileged thread on the main stack.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        gpr_q[i] <= cpu_state_pkg::WORD_RST;
      end
      msp_q        <= cpu_state_pkg::WORD_RST;
      psp_q        <= cpu_state_pkg::WORD_RST;
      application_status_q       <= cpu_state_pkg::WORD_RST;
      interrupt_status_number_q       <= cpu_state_pkg::WORD_RST;
      execution_status_q       <= cpu_state_pkg::EXECUTION_STATUS_RST;
      prim_q       <= 1'b0;
      fmask_q      <= 1'b0;
      bpri_q       <= '0;
      ctrl_q       <= cpu_state_pkg::CTRL_RST;
      saved_ctrl_q <= cpu_state_pkg::CTRL_RST;
      depth_q      <= 8'h00;
      state_q      <= cpu_state_pkg::ST_PRIV_THREAD;
      prdata_q     <= cpu_state_pkg::WORD_RST;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      fault_q      <= 1'b0;
      take_q       <= 1'b0;
      bb_hit_q     <= 1'b0;
      bb_word_q    <= cpu_state_pkg::WORD_RST;
      bb_bit_q     <= 5'h00;
      split_q      <= 1'b0;
      psp_active_q <= 1'b0;
    end else begin
      gpr_q        <= gpr_d;
      msp_q        <= msp_d;
      psp_q        <= psp_d;
      application_status_q       <= application_status_d;
      interrupt_status_number_q       <= interrupt_status_number_d;
      execution_status_q       <= execution_status_d;
      prim_q       <= prim_d;
      fmask_q      <= fmask_d;
      bpri_q       <= bpri_d;
      ctrl_q       <= ctrl_d;
      saved_ctrl_q <= saved_ctrl_d;
      depth_q      <= depth_d;
      state_q      <= state_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      fault_q      <= fault_d;
      take_q       <= take_d;
      bb_hit_q     <= bb_hit_d;
      bb_word_q    <= bb_word_d;
      bb_bit_q     <= bb_bit_d;
      split_q      <= split_d;
      psp_active_q <= psp_active_d;
    end
  end

  // ****************************************************************
  // Outputs, each straight from a flip-flop
  // ****************************************************************
  // No output has a combinational path through this block, so the bus
  // and the pipeline never see a glitch or a loop through it.
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign fault               = fault_q;
  assign irq_take            = take_q;
  assign op_state            = state_q;
  assign psp_active          = psp_active_q;
  assign instruction_pointer = gpr_q[cpu_state_pkg::IDX_PC];
  assign bb_hit              = bb_hit_q;
  assign bb_word_addr        = bb_word_q;
  assign bb_bit              = bb_bit_q;
  assign ua_split            = split_q;

endmodule

/* File: cpu_mode_and_core_registers_properties.sv */
`timescale 1ns/10ps
// ****************************************************************
// Port-level checks of the processor-state block
// ****************************************************************
module cpu_mode_and_core_registers_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        narrow_insn,
  input wire logic        exc_enter,
  input wire logic        call_valid,
  input wire logic [31:0] call_target,
  input wire logic        irq_valid,
  input wire logic        irq_is_nmi,
  input wire logic [31:0] bb_addr,
  input wire logic        fault,
  input wire logic        irq_take,
  input wire logic [2:0]  op_state,
  input wire logic        psp_active,
  input wire logic [31:0] instruction_pointer,
  input wire logic        bb_hit,
  input wire logic [4:0]  bb_bit
);
  logic access;

  // A transfer only takes effect at the edge that ends its access phase.
  assign access = psel && penable && pready;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_three_states: assert property (op_state inside {3'b001, 3'b010, 3'b100})
    else $error("operating state outside the three legal codes");
  a_stack_bank: assert property (psp_active == (op_state == 3'b100))
    else $error("process stack selection does not follow user thread state");
  a_enter_handler: assert property (exc_enter |=> op_state == 3'b001 && !psp_active)
    else $error("exception entry did not give privileged handler on main stack");
  a_pc_halfword: assert property (!instruction_pointer[0])
    else $error("instruction pointer is odd");
  a_call_target: assert property (call_valid |=>
      instruction_pointer == ($past(call_target) & cpu_state_pkg::PC_MASK))
    else $error("call did not load the instruction pointer");
  a_nmi_passes: assert property (irq_valid && irq_is_nmi |=> irq_take)
    else $error("nonmaskable request was masked");
  a_user_blocked: assert property (access && op_state == 3'b100
      && paddr == cpu_state_pkg::OFS_PRIM |-> pslverr ##1 fault)
    else $error("user access to a mask register was not refused with a fault");
  a_mode_bit_one: assert property (access && !pwrite && !pslverr
      && paddr == cpu_state_pkg::OFS_EXECUTION_STATUS |-> prdata[24])
    else $error("execution status read with the mode bit clear");
  a_narrow_high: assert property (access && narrow_insn && paddr[1:0] == 2'b00
      && paddr inside {[12'h020:12'h030]} |-> pslverr)
    else $error("high register reached by a narrow instruction");
  a_bb_bit: assert property (bb_hit |-> bb_bit == 5'($past(bb_addr) >> 2))
    else $error("alias bit index does not follow the alias address");

  // Main scenarios that the bench is expected to reach.
  c_exception: cover property (exc_enter ##1 op_state == 3'b001);
  c_user_fault: cover property (fault && op_state == 3'b100);
  c_irq_taken: cover property (irq_valid ##1 irq_take);
endmodule

bind cpu_mode_and_core_registers cpu_mode_and_core_registers_properties
  cpu_mode_and_core_registers_properties_inst (.*);

/* File: cpu_mode_and_core_registers_tb.sv */
`timescale 1ns/10ps
module cpu_mode_and_core_registers_tb;
  // ****************************************************************
  // Stimulus, observed outputs and counters
  // ****************************************************************
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        narrow_insn = 1'b0, exc_enter = 1'b0, exc_exit = 1'b0, call_valid = 1'b0;
  logic        flags_valid = 1'b0, irq_valid = 1'b0, irq_is_nmi = 1'b0;
  logic        irq_is_hardfault = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [8:0]  exc_num = 9'h000, exc_ret_num = 9'h000, irq_prio = 9'h000;
  logic [4:0]  flags_in = 5'h00;
  logic [2:0]  ua_bytes = 3'h1;
  logic [31:0] pwdata = 32'h0, call_ret_addr = 32'h0, call_target = 32'h0;
  logic [31:0] bb_addr = 32'h0, ua_addr = 32'h0;
  logic [31:0] prdata, instruction_pointer, bb_word_addr, rdv;
  logic        pready, pslverr, fault, irq_take, psp_active, bb_hit, ua_split, errv, flt;
  logic [2:0]  op_state;
  logic [4:0]  bb_bit;
  int          mismatches = 0;
  int          cmp_count = 0;

  cpu_mode_and_core_registers cpu_mode_and_core_registers_inst (.*);

  // Free-running 50 MHz clock.
  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1 flt = fault;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rdv, e);
  endtask

  // Entry or return pulse; the state has settled when the task ends.
  task automatic exc(input logic ent, input logic [8:0] n);
    @(posedge pclk);
    exc_enter <= ent;
    exc_exit <= !ent;
    exc_num <= n;
    exc_ret_num <= n;
    @(posedge pclk);
    exc_enter <= 1'b0;
    exc_exit <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic irq(input logic nmi, input logic hf, input logic [8:0] p, input logic e);
    @(posedge pclk);
    irq_valid <= 1'b1;
    irq_is_nmi <= nmi;
    irq_is_hardfault <= hf;
    irq_prio <= p;
    @(posedge pclk);
    irq_valid <= 1'b0;
    #1 check({31'h0, irq_take}, {31'h0, e});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a tenth of this span.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(cpu_state_pkg::OFS_EXECUTION_STATUS, cpu_state_pkg::EXECUTION_STATUS_RST);
    rdchk(cpu_state_pkg::OFS_STATE, 32'h0000_0002);
    rdchk(cpu_state_pkg::OFS_CTRL, 32'h0000_0000);
    wr(cpu_state_pkg::OFS_CORE, 32'hFFFF_FFFF);
    rdchk(cpu_state_pkg::OFS_CORE, 32'hFFFF_FFFF);
    wr(12'h01C, 32'h1234_5678);
    @(posedge pclk) narrow_insn <= 1'b1;
    rdchk(12'h01C, 32'h1234_5678);
    apb(1'b0, 12'h030, 32'h0000_0000);
    check({31'h0, errv}, 32'h1);
    @(posedge pclk) narrow_insn <= 1'b0;
    wr(12'h030, 32'hA5A5_5A5A);
    rdchk(12'h030, 32'hA5A5_5A5A);
    wr(12'h034, 32'h0000_1003);
    rdchk(12'h034, 32'h0000_1000);
    rdchk(cpu_state_pkg::OFS_MSP, 32'h0000_1000);
    wr(12'h03C, 32'h0000_2001);
    check(instruction_pointer, 32'h0000_2000);
    @(posedge pclk);
    call_valid <= 1'b1;
    call_ret_addr <= 32'h0000_3003;
    call_target <= 32'h0000_4005;
    @(posedge pclk);
    call_valid <= 1'b0;
    #1 check(instruction_pointer, 32'h0000_4004);
    rdchk(12'h038, 32'h0000_3003);
    @(posedge pclk);
    flags_valid <= 1'b1;
    flags_in <= 5'h1F;
    @(posedge pclk);
    flags_valid <= 1'b0;
    rdchk(cpu_state_pkg::OFS_APPLICATION_STATUS, cpu_state_pkg::APPLICATION_STATUS_MASK);
    rdchk(cpu_state_pkg::OFS_COMBINED_STATUS_WORD, 32'hF900_0000);
    apb(1'b1, cpu_state_pkg::OFS_EXECUTION_STATUS, 32'h0000_FC00);
    check({30'h0, errv, flt}, 32'h3);
    wr(cpu_state_pkg::OFS_EXECUTION_STATUS, 32'h0700_FC00);
    rdchk(cpu_state_pkg::OFS_EXECUTION_STATUS, 32'h0700_FC00);
    rdchk(cpu_state_pkg::OFS_COMBINED_STATUS_WORD, 32'hFF00_FC00);
    wr(cpu_state_pkg::OFS_EXECUTION_STATUS, cpu_state_pkg::EXECUTION_STATUS_RST);
    wr(cpu_state_pkg::OFS_FMASK, 32'h1);
    irq(1'b0, 1'b0, 9'h001, 1'b0);
    irq(1'b0, 1'b1, 9'h001, 1'b0);
    irq(1'b1, 1'b0, 9'h001, 1'b1);
    wr(cpu_state_pkg::OFS_FMASK, 32'h0);
    wr(cpu_state_pkg::OFS_PRIM, 32'h1);
    irq(1'b0, 1'b1, 9'h001, 1'b1);
    irq(1'b0, 1'b0, 9'h001, 1'b0);
    wr(cpu_state_pkg::OFS_PRIM, 32'h0);
    wr(cpu_state_pkg::OFS_BPRI, 32'h4);
    irq(1'b0, 1'b0, 9'h004, 1'b0);
    irq(1'b0, 1'b0, 9'h003, 1'b1);
    wr(cpu_state_pkg::OFS_BPRI, 32'h0);
    irq(1'b0, 1'b0, 9'h1FF, 1'b1);
    @(posedge pclk);
    bb_addr <= 32'h1200_028C;
    ua_addr <= 32'h0000_0102;
    ua_bytes <= 3'h4;
    @(posedge pclk);
    ua_addr <= 32'h0000_0104;
    #1 check({bb_word_addr[31:6], bb_bit, bb_hit}, {26'h040_0000, 5'h03, 1'b1});
    check({31'h0, ua_split}, 32'h1);
    @(posedge pclk);
    #1 check({31'h0, ua_split}, 32'h0);
    check(bb_word_addr, 32'h1000_0014);
    apb(1'b0, 12'h070, 32'h0000_0000);
    check({30'h0, errv, flt}, 32'h2);
    exc(1'b1, 9'h1AB);
    check({29'h0, op_state}, 32'h1);
    rdchk(cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER, 32'h0000_01AB);
    exc(1'b1, 9'h005);
    rdchk(cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER, 32'h0000_0005);
    exc(1'b0, 9'h1AB);
    rdchk(cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER, 32'h0000_01AB);
    exc(1'b0, 9'h000);
    check({29'h0, op_state}, 32'h2);
    rdchk(cpu_state_pkg::OFS_INTERRUPT_STATUS_NUMBER, 32'h0000_0000);
    wr(cpu_state_pkg::OFS_MSP, 32'h0000_0100);
    wr(cpu_state_pkg::OFS_PSP, 32'h0000_0203);
    wr(cpu_state_pkg::OFS_CTRL, 32'h1);
    rdchk(cpu_state_pkg::OFS_STATE, 32'h0000_000C);
    rdchk(12'h034, 32'h0000_0200);
    apb(1'b0, cpu_state_pkg::OFS_PRIM, 32'h0000_0000);
    check({30'h0, errv, flt}, 32'h3);
    exc(1'b1, 9'h010);
    check({28'h0, psp_active, op_state}, 32'h1);
    rdchk(12'h034, 32'h0000_0100);
    wr(cpu_state_pkg::OFS_CTRL, 32'h3);
    rdchk(cpu_state_pkg::OFS_CTRL, 32'h1);
    exc(1'b0, 9'h000);
    check({29'h0, op_state}, 32'h4);
    print_verdict();
  end
endmodule
